// file: rtl/cief_pkg.sv
// Package for the core interrupt enable and flag block.
// Assumes one 40 MHz core clock and an APB register port.
package cief_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] CIEF_OFS_CTRL  = 8'h00;
    localparam logic [7:0] CIEF_OFS_PEN1  = 8'h04;
    localparam logic [7:0] CIEF_OFS_PINEN = 8'h08;
    localparam logic [7:0] CIEF_OFS_OPT   = 8'h0c;
    localparam logic [7:0] CIEF_OFS_PFLAG = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CIEF_BIT_GLB_EN    = 7;
    localparam int CIEF_BIT_GRP_EN    = 6;
    localparam int CIEF_BIT_T0_EN     = 5;
    localparam int CIEF_BIT_EDGE_EN   = 4;
    localparam int CIEF_BIT_PORT_EN   = 3;
    localparam int CIEF_BIT_T0_FLAG   = 2;
    localparam int CIEF_BIT_EDGE_FLAG = 1;
    localparam int CIEF_BIT_PORT_FLAG = 0;
    localparam int CIEF_BIT_T1G  = 7;
    localparam int CIEF_BIT_ADC  = 6;
    localparam int CIEF_BIT_RX   = 5;
    localparam int CIEF_BIT_TX   = 4;
    localparam int CIEF_BIT_SSP  = 3;
    localparam int CIEF_BIT_CCP1 = 2;
    localparam int CIEF_BIT_TMR2 = 1;
    localparam int CIEF_BIT_TMR1 = 0;
    localparam int CIEF_BIT_POL  = 0;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [7:0]  CIEF_RST_CTRL  = 8'h00;
    localparam logic [7:0]  CIEF_RST_PEN1  = 8'h00;
    localparam logic [7:0]  CIEF_RST_PINEN = 8'h00;
    localparam logic        CIEF_RST_POL   = 1'b1;
    localparam logic [12:0] CIEF_VECTOR    = 13'h0004;
    localparam logic [31:0] CIEF_RD_ZERO   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic timer0_overflow_irq_enable;
        logic edge_pin_irq_enable;
        logic port_change_irq_enable;
        logic timer0_overflow_flag;
        logic edge_pin_flag;
        logic port_change_flag;
    } cief_ctrl_t;

    typedef struct packed {
        logic flush;
        logic push_pc;
        logic load_vector;
    } cief_entry_t;

    typedef enum logic [0:0] {
        CIEF_IDLE,
        CIEF_ACK
    } cief_apb_st_t;

endpackage

// file: rtl/cief_event_detect.sv
// Edge pin and port change detector.
// Assumes pins are already synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module cief_event_detect
    import cief_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            edge_pin,
    input  wire logic            edge_polarity_select,
    input  wire logic [PINS-1:0] port_pins,
    input  wire logic [PINS-1:0] per_pin_change_enable,
    output logic                 edge_evt_q,
    output logic                 change_evt_q
);

    // ----------------------------------------------------------------
    // Previous samples
    // ----------------------------------------------------------------
    logic            edge_prev_q;
    logic [PINS-1:0] port_prev_q;
    wire logic       rise_w   = edge_pin & ~edge_prev_q;
    wire logic       fall_w   = ~edge_pin & edge_prev_q;
    wire logic       edge_w   = edge_polarity_select ? rise_w : fall_w;
    wire logic       change_w = |((port_pins ^ port_prev_q) & per_pin_change_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_prev_q  <= 1'b0;
            port_prev_q  <= '0;
            edge_evt_q   <= 1'b0;
            change_evt_q <= 1'b0;
        end else begin
            edge_prev_q  <= edge_pin;
            port_prev_q  <= port_pins;
            edge_evt_q   <= edge_w;
            change_evt_q <= change_w;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_edge_rising: assert property (@(posedge pclk) disable iff (!presetn)
        edge_polarity_select && edge_pin && !$past(edge_pin) |=> edge_evt_q)
        else $error("rising edge missed");
    a_edge_falling: assert property (@(posedge pclk) disable iff (!presetn)
        !edge_polarity_select && edge_pin && !$past(edge_pin) |=> !edge_evt_q)
        else $error("rising edge taken in falling mode");
    a_change_gated: assert property (@(posedge pclk) disable iff (!presetn)
        per_pin_change_enable == '0 |=> !change_evt_q)
        else $error("change event from disabled pin");

endmodule
`default_nettype wire

// file: rtl/cief_core_irq.sv
// Interrupt enable and flag registers of the core, with APB access.
// Assumes raw event pulses from peripherals and core handshake inputs.
//
// Functional notes
// - Flags latch on their event regardless of the global, group and interrupt enable bits.
// - Control register read/write: global, group, three enables, three flags.
// - Peripheral-register sources need the group enable to request.
// - Port change fires only for pins with their change-detect enable set.
// - Timer0 overflow flag sets when the timer wraps.
// - Edge and port change flags stay set until software writes zero.
// - Bit 7 of peripheral enable gates the timer1 gate event.
// - Bits 5 and 4 gate serial receive and transmit.
// - Bit 2 gates the capture/compare 1 event.
// - Bit 1 gates the timer2 period match event.
// - Accept flushes, clears global enable, pushes PC, loads vector 0004h.
// - Edge flag on rising edge if polarity one, else falling edge.
// - All enable bits read zero after reset.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module cief_core_irq
    import cief_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PINS   = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              timer0_wrap,
    input  wire logic              edge_pin,
    input  wire logic [PINS-1:0]   port_pins,
    input  wire logic [7:0]        periph_flags,
    input  wire logic              core_accept,
    input  wire logic              core_return,
    output logic                   irq_req_q,
    output cief_entry_t            entry_q,
    output logic [12:0]            vector_addr_q
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cief_apb_st_t    st_q;
    cief_apb_st_t    st_d;
    cief_ctrl_t      ctrl_q;
    cief_ctrl_t      ctrl_d;
    logic [7:0]      pen1_q;
    logic [7:0]      pen1_d;
    logic [PINS-1:0] pinen_q;
    logic [PINS-1:0] pinen_d;
    logic            pol_q;
    logic            pol_d;
    logic [31:0]     rdata_d;
    logic            edge_evt;
    logic            change_evt;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic hit_ctrl  = hit(paddr, CIEF_OFS_CTRL);
    wire logic hit_pen1  = hit(paddr, CIEF_OFS_PEN1);
    wire logic hit_pinen = hit(paddr, CIEF_OFS_PINEN);
    wire logic hit_opt   = hit(paddr, CIEF_OFS_OPT);
    wire logic hit_pflag = hit(paddr, CIEF_OFS_PFLAG);
    wire logic mapped    = hit_ctrl | hit_pen1 | hit_pinen | hit_opt | hit_pflag;
    wire logic setup     = psel & ~penable & (st_q == CIEF_IDLE);
    // Writes land only at the completing access edge
    wire logic commit    = psel & penable & pready;
    wire logic wr_lane0  = commit & pwrite & pstrb[0];
    wire logic wr_ctrl   = wr_lane0 & hit_ctrl;
    wire logic wr_pen1   = wr_lane0 & hit_pen1;
    wire logic wr_pinen  = wr_lane0 & hit_pinen;
    wire logic wr_opt    = wr_lane0 & hit_opt;
    wire cief_ctrl_t wctl = cief_ctrl_t'(pwdata[7:0]);

    always_comb begin
        rdata_d = CIEF_RD_ZERO;
        if (hit_ctrl) begin
            rdata_d[7:0] = ctrl_q;
        end else if (hit_pen1) begin
            rdata_d[7:0] = pen1_q;
        end else if (hit_pinen) begin
            rdata_d[PINS-1:0] = pinen_q;
        end else if (hit_opt) begin
            rdata_d[CIEF_BIT_POL] = pol_q;
        end else if (hit_pflag) begin
            rdata_d[7:0] = periph_flags;
        end
    end

    always_comb begin
        st_d = st_q;
        case (st_q)
            CIEF_IDLE: begin
                if (setup) begin
                    st_d = CIEF_ACK;
                end
            end
            CIEF_ACK: begin
                st_d = CIEF_IDLE;
            end
            default: begin
                st_d = CIEF_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= CIEF_IDLE;
            pready  <= 1'b0;
            prdata  <= CIEF_RD_ZERO;
            pslverr <= 1'b0;
        end else begin
            st_q    <= st_d;
            pready  <= setup;
            prdata  <= setup && !pwrite ? rdata_d : CIEF_RD_ZERO;
            pslverr <= setup & ~mapped;
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    cief_event_detect #(
        .PINS (PINS)
    ) u_detect (
        .pclk                  (pclk),
        .presetn               (presetn),
        .edge_pin              (edge_pin),
        .edge_polarity_select  (pol_q),
        .port_pins             (port_pins),
        .per_pin_change_enable (pinen_q),
        .edge_evt_q            (edge_evt),
        .change_evt_q          (change_evt)
    );

    // ----------------------------------------------------------------
    // Control register next value
    // ----------------------------------------------------------------
    // Besides a control register write, only a taken request may close the global enable
    wire logic accept_w = core_accept & irq_req_q & ctrl_q.global_irq_enable;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wctl;
        end
        if (accept_w) begin
            ctrl_d.global_irq_enable = 1'b0;
        end else if (core_return) begin
            ctrl_d.global_irq_enable = 1'b1;
        end
        // Hardware set beats a same-cycle software clear
        if (timer0_wrap) begin
            ctrl_d.timer0_overflow_flag = 1'b1;
        end
        if (edge_evt) begin
            ctrl_d.edge_pin_flag = 1'b1;
        end
        if (change_evt) begin
            ctrl_d.port_change_flag = 1'b1;
        end
    end

    assign pen1_d  = wr_pen1 ? pwdata[7:0] : pen1_q;
    assign pinen_d = wr_pinen ? pwdata[PINS-1:0] : pinen_q;
    assign pol_d   = wr_opt ? pwdata[CIEF_BIT_POL] : pol_q;

    // ----------------------------------------------------------------
    // Request combine
    // ----------------------------------------------------------------
    wire logic core_src = (ctrl_q.timer0_overflow_irq_enable & ctrl_q.timer0_overflow_flag)
                        | (ctrl_q.edge_pin_irq_enable & ctrl_q.edge_pin_flag)
                        | (ctrl_q.port_change_irq_enable & ctrl_q.port_change_flag);
    // Gating per bit: T1G, ADC, RX, TX, SSP, CCP1, TMR2, TMR1
    wire logic [7:0] per_hit = pen1_q & periph_flags;
    wire logic per_src  = ctrl_q.peripheral_group_enable & (|per_hit);
    wire logic irq_d    = ctrl_q.global_irq_enable & (core_src | per_src);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q        <= cief_ctrl_t'(CIEF_RST_CTRL);
            pen1_q        <= CIEF_RST_PEN1;
            pinen_q       <= PINS'(CIEF_RST_PINEN);
            pol_q         <= CIEF_RST_POL;
            irq_req_q     <= 1'b0;
            entry_q       <= '0;
            vector_addr_q <= CIEF_VECTOR;
        end else begin
            ctrl_q        <= ctrl_d;
            pen1_q        <= pen1_d;
            pinen_q       <= pinen_d;
            pol_q         <= pol_d;
            irq_req_q     <= irq_d & ~accept_w;
            entry_q       <= {accept_w, accept_w, accept_w};
            vector_addr_q <= CIEF_VECTOR;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_t0_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        timer0_wrap |=> ctrl_q.timer0_overflow_flag)
        else $error("timer0 overflow flag not set");
    a_flag_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
        edge_evt && !ctrl_q.global_irq_enable && !ctrl_q.edge_pin_irq_enable
        |=> ctrl_q.edge_pin_flag)
        else $error("flag blocked by enables");
    a_flags_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.port_change_flag && !wr_ctrl |=> ctrl_q.port_change_flag)
        else $error("port change flag cleared by hardware");
    a_group_gates: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.peripheral_group_enable && !core_src |=> !irq_req_q)
        else $error("grouped source requested without group enable");
    a_t1g_request: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.global_irq_enable && ctrl_q.peripheral_group_enable && !core_accept
        && pen1_q[CIEF_BIT_T1G] && periph_flags[CIEF_BIT_T1G] |=> irq_req_q)
        else $error("timer1 gate event not requested");
    a_serial_block: assert property (@(posedge pclk) disable iff (!presetn)
        !core_src && (periph_flags & ~pen1_q) == periph_flags |=> !irq_req_q)
        else $error("disabled serial or peripheral source requested");
    a_ccp_tmr2_req: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.global_irq_enable && ctrl_q.peripheral_group_enable && !core_accept
        && ((pen1_q[CIEF_BIT_CCP1] && periph_flags[CIEF_BIT_CCP1])
        || (pen1_q[CIEF_BIT_TMR2] && periph_flags[CIEF_BIT_TMR2])) |=> irq_req_q)
        else $error("capture or timer2 event not requested");
    a_req_needs_gie: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req_q |-> $past(ctrl_q.global_irq_enable))
        else $error("request without global enable");
    a_accept_entry: assert property (@(posedge pclk) disable iff (!presetn)
        accept_w |=> !ctrl_q.global_irq_enable && entry_q.flush && entry_q.load_vector
        && vector_addr_q == CIEF_VECTOR ##1 !entry_q.flush)
        else $error("accept sequence wrong");
    a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_ctrl |=> prdata[7:0] == $past(ctrl_q) && pready)
        else $error("control readback mismatch");

    c_core_irq: cover property (@(posedge pclk) disable iff (!presetn)
        core_src && ctrl_q.global_irq_enable ##1 irq_req_q);
    c_periph_irq: cover property (@(posedge pclk) disable iff (!presetn)
        per_src && !core_src ##1 irq_req_q);
    c_accept: cover property (@(posedge pclk) disable iff (!presetn) accept_w);
    c_set_vs_clear: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !wctl.timer0_overflow_flag && timer0_wrap);

endmodule
`default_nettype wire

// file: verification/cief_core_model.sv
// Behavioural core sequencer facing the interrupt block.
// Assumes pclk and presetn are shared with the block.
`timescale 1ns/10ps
`default_nettype none
module cief_core_model
    import cief_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        irq_req_q,
    input  wire cief_entry_t entry_q,
    input  wire logic        accept_en,
    input  wire logic [3:0]  ack_dly,
    input  wire logic        ret_req,
    output logic             core_accept,
    output logic             core_return,
    output logic [7:0]       entries_q
);
    logic [3:0] wait_q;
    logic       taken_q;

    // One accept per enable window, so a held request is not taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q      <= 4'h0;
            taken_q     <= 1'b0;
            core_accept <= 1'b0;
            core_return <= 1'b0;
            entries_q   <= 8'h00;
        end else begin
            core_accept <= 1'b0;
            core_return <= ret_req;
            if (entry_q == 3'h7) begin
                entries_q <= entries_q + 8'h01;
            end
            if (!accept_en) begin
                taken_q <= 1'b0;
                wait_q  <= 4'h0;
            end else if (irq_req_q && !taken_q) begin
                if (wait_q == ack_dly) begin
                    core_accept <= 1'b1;
                    taken_q     <= 1'b1;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/core_interrupt_enable_flags_tb.sv
// Self-checking bench for the core interrupt enable and flag block.
// Assumes the block answers APB with one access cycle, core model beside it.
`timescale 1ns/10ps
`default_nettype none
module core_interrupt_enable_flags_tb
    import cief_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, irq_req_q, core_accept, core_return;
    logic [31:0] prdata;
    logic        timer0_wrap = 1'b0, edge_pin = 1'b0;
    logic [7:0]  port_pins = 8'h00, periph_flags = 8'h00, entries_q;
    logic        accept_en = 1'b0, ret_req = 1'b0;
    logic [3:0]  ack_dly = 4'h0;
    cief_entry_t entry_q;
    logic [12:0] vector_addr_q;
    int          err_total = 0, comparisons = 0;

    always #12.5 pclk = ~pclk;

    cief_core_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .timer0_wrap(timer0_wrap), .edge_pin(edge_pin),
        .port_pins(port_pins), .periph_flags(periph_flags), .core_accept(core_accept),
        .core_return(core_return), .irq_req_q(irq_req_q), .entry_q(entry_q),
        .vector_addr_q(vector_addr_q));

    cief_core_model core (.pclk(pclk), .presetn(presetn), .irq_req_q(irq_req_q),
        .entry_q(entry_q), .accept_en(accept_en), .ack_dly(ack_dly), .ret_req(ret_req),
        .core_accept(core_accept), .core_return(core_return), .entries_q(entries_q));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is sampled high; only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        chk("read data", exp, d);
        chk("slave error", {31'h0, ee}, {31'h0, e});
    endtask

    task automatic wrap_pulse;
        @(posedge pclk);
        timer0_wrap <= 1'b1;
        @(posedge pclk);
        timer0_wrap <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        #500000;
        err_total++;
        test_done;
    end

    initial begin
        logic [7:0] m;
        cyc(2);
        presetn <= 1'b1;
        rdc(CIEF_OFS_CTRL, 32'h00, 1'b0);
        rdc(CIEF_OFS_PEN1, 32'h00, 1'b0);
        chk("vector", 32'h4, {19'h0, vector_addr_q});
        wr(CIEF_OFS_CTRL, 32'h7f);
        rdc(CIEF_OFS_CTRL, 32'h7f, 1'b0);
        wr(CIEF_OFS_CTRL, 32'h00);
        rdc(CIEF_OFS_CTRL, 32'h00, 1'b0);
        wr(CIEF_OFS_PEN1, 32'hff);
        rdc(CIEF_OFS_PEN1, 32'hff, 1'b0);
        wr(CIEF_OFS_PEN1, 32'h00);
        rdc(8'h14, 32'h00, 1'b1);
        wrap_pulse;
        cyc(2);
        rdc(CIEF_OFS_CTRL, 32'h04, 1'b0);
        chk("request", 32'h0, {31'h0, irq_req_q});
        wr(CIEF_OFS_CTRL, 32'h00);
        edge_pin <= 1'b1;
        cyc(3);
        edge_pin <= 1'b0;
        cyc(20);
        rdc(CIEF_OFS_CTRL, 32'h02, 1'b0);
        wr(CIEF_OFS_OPT, 32'h00);
        wr(CIEF_OFS_CTRL, 32'h00);
        edge_pin <= 1'b1;
        cyc(3);
        rdc(CIEF_OFS_CTRL, 32'h00, 1'b0);
        edge_pin <= 1'b0;
        cyc(3);
        rdc(CIEF_OFS_CTRL, 32'h02, 1'b0);
        wr(CIEF_OFS_CTRL, 32'h00);
        port_pins <= 8'h02;
        cyc(3);
        rdc(CIEF_OFS_CTRL, 32'h00, 1'b0);
        wr(CIEF_OFS_PINEN, 32'h01);
        port_pins <= 8'h03;
        cyc(3);
        rdc(CIEF_OFS_CTRL, 32'h01, 1'b0);
        wr(CIEF_OFS_CTRL, 32'h00);
        // Prompt core, then a slow one
        for (int k = 0; k < 2; k++) begin
            accept_en <= 1'b1;
            ack_dly   <= (k == 0) ? 4'h0 : 4'h4;
            wr(CIEF_OFS_CTRL, 32'ha0);
            wrap_pulse;
            cyc(2);
            chk("request", 32'h1, {31'h0, irq_req_q});
            cyc(10);
            rdc(CIEF_OFS_CTRL, 32'h24, 1'b0);
            chk("request", 32'h0, {31'h0, irq_req_q});
            chk("entries", k + 1, {24'h0, entries_q});
            wr(CIEF_OFS_CTRL, 32'h20);
            accept_en <= 1'b0;
            ret_req   <= 1'b1;
            @(posedge pclk);
            ret_req   <= 1'b0;
            cyc(2);
            rdc(CIEF_OFS_CTRL, 32'ha0, 1'b0);
            wr(CIEF_OFS_CTRL, 32'h00);
        end
        // Peripheral group gating, every enable bit
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            periph_flags <= m;
            wr(CIEF_OFS_PEN1, {24'h0, m});
            rdc(CIEF_OFS_PFLAG, {24'h0, m}, 1'b0);
            wr(CIEF_OFS_CTRL, 32'h80);
            cyc(3);
            chk("request", 32'h0, {31'h0, irq_req_q});
            wr(CIEF_OFS_CTRL, 32'hc0);
            cyc(3);
            chk("request", 32'h1, {31'h0, irq_req_q});
            wr(CIEF_OFS_PEN1, {24'h0, ~m});
            cyc(3);
            chk("request", 32'h0, {31'h0, irq_req_q});
        end
        periph_flags <= 8'h00;
        wr(CIEF_OFS_PEN1, 32'hff);
        wr(CIEF_OFS_CTRL, 32'h78);
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        rdc(CIEF_OFS_CTRL, 32'h00, 1'b0);
        rdc(CIEF_OFS_PEN1, 32'h00, 1'b0);
        test_done;
    end
endmodule
`default_nettype wire
